// file: sim/spectro_cmd_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////
// spectrometer command input, far side of the serial port
module spectro_cmd_model
	import tcd_pkg::*;
(
	input wire ser_t ser,
	output logic [15:0] word
);
	// msb-first capture
	// data changes on the falling edge of the serial clock, or with the clock low as the frame opens, so take it on the rise
	always @(posedge ser.clk) begin
		if (ser.frame) begin
			word <= {word[14:0], ser.data};
		end
	end
endmodule

// file: sim/telecommand_dispatch_test.sv
`timescale 1ns/1ps
`include "tcd_consts.svh"
module telecommand_dispatch_test
	import tcd_pkg::*;
;
	logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, er, prev_fr;
	logic mirror_move, ack_accept, ack_exec, cal_start, cmd_reject;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0] mirror_target;
	logic [15:0] word, v;
	logic [10:0] seq;
	ser_t ser_out;
	logic [31:0] evq[$];
	int n_fail, checks_done;

	telecommand_dispatch i_telecommand_dispatch(.pclk(pclk), .presetn(presetn), .ce(ce),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr), .ser_out(ser_out),
		.mirror_target(mirror_target), .mirror_move(mirror_move), .ack_accept(ack_accept),
		.ack_exec(ack_exec), .cal_start(cal_start), .cmd_reject(cmd_reject));
	spectro_cmd_model i_spectro_cmd_model(.ser(ser_out), .word(word));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	////////////////////////////////////////////////////////////////
	task automatic final_report();
		$display("checks %0d errors %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// apb master: hold the request until pready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 500);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 500) begin
			n_fail++;
			final_report();
		end
	endtask

	function automatic logic [15:0] crc(input logic [95:0] b);
		logic [15:0] c;
		c = `CRC_INIT;
		for (int i = 95; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? `CRC_POLY : 16'h0);
		return c;
	endfunction

	function automatic pkt_t mk(input logic [7:0] sub, input logic [3:0] ack, input logic [15:0] d);
		pkt_t p;
		p = {8'h1C, 8'h7C, 2'h3, 3'h0, seq, 16'h0007, 4'h1, ack, 8'hC0, sub, 8'h00, d, 16'h0000};
		seq++;
		return p;
	endfunction

	task automatic send(input pkt_t p, input logic bad);
		p.pec = crc(p[111:16]) ^ {15'h0, bad};
		for (int i = 13; i >= 0; i--) apb(1'b1, `A_PKT, {24'h0, p[i*8 +: 8]});
	endtask

	// wait for all noted results, bounded
	task automatic drain();
		int n;
		n = 0;
		while (evq.size() > 0 && n < 1000) begin
			@(posedge pclk);
			n++;
		end
		if (evq.size() > 0) begin
			n_fail++;
			final_report();
		end
		repeat (3) @(posedge pclk);
	endtask
	////////////////////////////////////////////////////////////////
	// watcher: each result pulse takes the oldest note, fixed order in a cycle
	task automatic note(input logic [31:0] got);
		if (evq.size() == 0) chk(got, 32'hFFFFFFFF);
		else chk(got, evq.pop_front());
	endtask

	always @(posedge pclk) begin
		if (presetn !== 1'b1) begin
			prev_fr = 1'b0;
		end else begin
			if (ack_accept === 1'b1) note(32'h00010000);
			if (cmd_reject === 1'b1) note(32'h00020000);
			if (mirror_move === 1'b1) note({16'h3, 14'h0, mirror_target});
			if (prev_fr === 1'b1 && ser_out.frame === 1'b0) note({16'h4, word});
			if (ack_exec === 1'b1) note(32'h00050000);
			if (cal_start === 1'b1) note(32'h00060000);
			prev_fr = ser_out.frame;
		end
	end
	////////////////////////////////////////////////////////////////
	initial begin
		pkt_t p;
		int nf;
		psel = 1'b0;
		ce = 1'b1;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		presetn = 1'b0;
		n_fail = 0;
		checks_done = 0;
		seq = 11'h000;
		prev_fr = 1'b0;
		void'($urandom(32'h9C41AE8D));
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `A_PPOS, 32'h0);
		chk(rd, 32'h0000019A);
		apb(1'b0, `A_STAT, 32'h0);
		chk({30'h0, rd[10:9]}, 32'h1);
		apb(1'b0, 8'h20, 32'h0);
		chk({31'h0, er}, 32'h1);
		// calibration on the default word, then a random position command
		evq.push_back({16'h4, `PP_DEFAULT});
		evq.push_back(32'h00060000);
		apb(1'b1, `A_CTRL, 32'h2);
		drain();
		v = 16'($urandom());
		evq.push_back(32'h00010000);
		evq.push_back({16'h4, v});
		evq.push_back(32'h00050000);
		// no position command while a word is still going out
		send(mk(`SUB_PP, `ACK_PP, v), 1'b0);
		// freeze the block in mid-word; the word must still arrive whole
		repeat (20) @(posedge pclk);
		nf = 1 + int'($urandom() % 16);
		ce <= 1'b0;
		repeat (nf) @(posedge pclk);
		ce <= 1'b1;
		drain();
		apb(1'b0, `A_PPOS, 32'h0);
		chk(rd, {16'h0, v});
		evq.push_back({16'h4, v});
		evq.push_back(32'h00060000);
		apb(1'b1, `A_CTRL, 32'h2);
		drain();
		// restart in mid-run
		presetn <= 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `A_PPOS, 32'h0);
		chk(rd, 32'h0000019A);
		// a half packet cleared by software must not disturb the next one
		apb(1'b1, `A_PKT, 32'h0000001C);
		apb(1'b1, `A_PKT, 32'h0000007C);
		apb(1'b1, `A_CTRL, 32'h00000001);
		// every mirror target, ending on cold
		for (int t = 1; t <= 3; t++) begin
			evq.push_back(32'h00010000);
			evq.push_back({16'h3, 16'(t)});
			send(mk(`SUB_MIR, `ACK_MIR, 16'(t)), 1'b0);
			drain();
		end
		// each malformed packet is discarded with no serial word
		for (int i = 0; i < 12; i++) begin
			p = (i == 7 || i == 8) ? mk(`SUB_MIR, `ACK_MIR, (i == 7) ? 16'h0 : 16'h4) :
				mk(`SUB_PP, `ACK_PP, 16'h1234);
			case (i)
				0: p.apid = 7'h46;
				1: p.cat = 4'hD;
				2: p.len = 16'h0008;
				3: p.pus = 3'h1;
				4: p.svc = 8'hC1;
				5: p.sub = 8'h0E;
				6: p.ack = `ACK_MIR;
				9: p.pad = 8'h01;
				10: p.seqf = 2'h2;
				default: p.ver = 3'h0;
			endcase
			evq.push_back(32'h00020000);
			send(p, i == 11);
			drain();
		end
		apb(1'b0, `A_STAT, 32'h0);
		chk({30'h0, rd[10:9]}, 32'h3);
		apb(1'b0, `A_CNT, 32'h0);
		chk(rd, 32'h000C0003);
		final_report();
	end
endmodule

// file: src/tcd_consts.svh
`ifndef TCD_CONSTS_SVH
`define TCD_CONSTS_SVH

// register byte addresses, address width
`define A_CTRL 8'h00
`define A_PKT 8'h04
`define A_STAT 8'h08
`define A_PPOS 8'h0C
`define A_CNT 8'h10
`define A_W 8

// control bits
`define C_CLR 0
`define C_CAL 1

// fixed header values
`define H_VER 3'h0
`define H_TYPE 1'h1
`define H_DFH 1'h1
`define H_APID 7'h47
`define H_CAT 4'hC
`define H_SEQF 2'h3
`define H_LEN 16'h0007
`define H_PUS 3'h0
`define H_CKF 1'h1
`define H_PTYPE 8'hC0
`define H_PAD 8'h00
`define SUB_PP 8'h0D
`define SUB_MIR 8'h66
`define ACK_PP 4'h9
`define ACK_MIR 4'h1

// mirror target codes
`define MIR_SPACE 2'h1
`define MIR_COLD 2'h3

// stored pulse position after reset
`define PP_DEFAULT 16'h019A

// checksum, ccitt polynomial, all-ones seed
`define CRC_POLY 16'h1021
`define CRC_INIT 16'hFFFF

// packet framing in bytes, last serial word bit in bits
`define PKT_LAST 4'hD
`define PEC_FIRST 4'hC
`define WORD_LAST 5'h0F

// serial half period: least time, rounded up
`define CLK_NS 10
`define SER_HALF_NS 50
`define SER_HALF_CYC 8'((`SER_HALF_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// file: src/tcd_pkg.sv
package tcd_pkg;

	// gray codes along collect, check, send, calibrate
	typedef enum logic [1:0] {
		ST_COLLECT = 2'h0,
		ST_CHECK = 2'h1,
		ST_SEND = 2'h3,
		ST_CALGO = 2'h2
	} st_e_t;

	typedef struct packed {
		logic clk;
		logic data;
		logic frame;
	} ser_t;

	// packet image, first byte in the top bits
	typedef struct packed {
		logic [2:0] ver;
		logic ptype;
		logic dfh;
		logic [6:0] apid;
		logic [3:0] cat;
		logic [1:0] seqf;
		logic [13:0] seqc;
		logic [15:0] len;
		logic [2:0] pus;
		logic ckf;
		logic [3:0] ack;
		logic [7:0] svc;
		logic [7:0] sub;
		logic [7:0] pad;
		logic [15:0] data;
		logic [15:0] pec;
	} pkt_t;

endpackage

// file: src/telecommand_dispatch.sv
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "tcd_consts.svh"

module telecommand_dispatch
	import tcd_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`A_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	output ser_t ser_out,
	output logic [1:0] mirror_target,
	output logic mirror_move,
	output logic ack_accept,
	output logic ack_exec,
	output logic cal_start,
	output logic cmd_reject
);

	typedef struct packed {
		st_e_t state;
		logic [111:0] pbuf;
		logic [3:0] idx;
		logic [15:0] crc;
		logic [15:0] ppos;
		logic cal_pend;
		logic cal_run;
		logic [15:0] sh;
		logic [4:0] nbit;
		logic [7:0] div;
		ser_t ser;
		logic [1:0] mir;
		logic mir_move;
		logic ack_acc;
		logic ack_exe;
		logic cal_go;
		logic rej;
		logic last_ok;
		logic last_rej;
		logic [15:0] nacc;
		logic [15:0] nrej;
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
	} state_t;

	state_t s_r;
	state_t s_nxt;
	pkt_t pkt;
	logic hdr_ok;
	logic pp_ok;
	logic mir_ok;
	logic wr_pkt;
	logic acc;
	logic cal_take;

	////////////////////////////////////////////////////////////////////////
	// helpers

	// bitwise ccitt update; one byte per call keeps the path short
	function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 7; i >= 0; i--) begin
			if (r[15] ^ d[i]) begin
				r = {r[14:0], 1'b0} ^ `CRC_POLY;
			end else begin
				r = {r[14:0], 1'b0};
			end
		end
		return r;
	endfunction

	// sole word launcher
	// load a word into the serialiser, msb first, clock idle low
	function automatic state_t start_send(input state_t s, input logic [15:0] v);
		state_t t;
		t = s;
		t.state = ST_SEND;
		t.sh = v;
		t.nbit = '0;
		t.div = '0;
		t.ser.frame = 1'b1;
		t.ser.clk = 1'b0;
		t.ser.data = v[15];
		return t;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// packet decode

	// header fields seen through the packed image
	always_comb begin
		pkt = pkt_t'(s_r.pbuf);
		hdr_ok = pkt.ver == `H_VER && pkt.ptype == `H_TYPE && pkt.dfh == `H_DFH
			&& pkt.apid == `H_APID && pkt.cat == `H_CAT && pkt.seqf == `H_SEQF
			&& pkt.len == `H_LEN && pkt.pus == `H_PUS && pkt.ckf == `H_CKF
			&& pkt.svc == `H_PTYPE && pkt.pad == `H_PAD
			&& pkt.pec == s_r.crc;
		pp_ok = hdr_ok && pkt.sub == `SUB_PP && pkt.ack == `ACK_PP;
		mir_ok = hdr_ok && pkt.sub == `SUB_MIR && pkt.ack == `ACK_MIR
			&& pkt.data >= 16'(`MIR_SPACE) && pkt.data <= 16'(`MIR_COLD);
	end

	// bytes are only taken while collecting; otherwise pready stalls
	assign wr_pkt = psel && pwrite && paddr == `A_PKT;
	assign acc = psel && penable && s_r.pready;
	assign cal_take = s_r.state == ST_COLLECT && s_r.idx == '0 && s_r.cal_pend;

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		s_nxt = s_r;
		s_nxt.mir_move = 1'b0;
		s_nxt.ack_acc = 1'b0;
		s_nxt.ack_exe = 1'b0;
		s_nxt.cal_go = 1'b0;
		s_nxt.rej = 1'b0;

		// apb answer, zero wait unless a packet byte must wait
		s_nxt.pready = psel && !s_r.pready && (!wr_pkt || s_r.state == ST_COLLECT);
		s_nxt.pslverr = 1'b0;
		s_nxt.prdata = '0;
		if (psel && !s_r.pready) begin
			unique case (paddr)
				`A_CTRL, `A_PKT: s_nxt.prdata = '0;
				`A_STAT: s_nxt.prdata = {21'h000000, s_r.mir, s_r.ser.frame,
					s_r.last_rej, s_r.last_ok, s_r.state != ST_COLLECT,
					s_r.cal_pend, s_r.idx};
				`A_PPOS: s_nxt.prdata = {16'h0000, s_r.ppos};
				`A_CNT: s_nxt.prdata = {s_r.nrej, s_r.nacc};
				default: s_nxt.pslverr = 1'b1;
			endcase
		end

		unique case (s_r.state)
			ST_COLLECT: begin
				// calibration first sends the stored position
				if (cal_take) begin
					s_nxt = start_send(s_nxt, s_r.ppos);
					s_nxt.cal_pend = 1'b0;
					s_nxt.cal_run = 1'b1;
				end
			end
			ST_CHECK: begin
				s_nxt.state = ST_COLLECT;
				s_nxt.crc = `CRC_INIT;
				if (pp_ok) begin
					s_nxt = start_send(s_nxt, pkt.data);
					s_nxt.ppos = pkt.data;
					s_nxt.cal_run = 1'b0;
				end else if (mir_ok) begin
					// drive mirror to the preset position
					s_nxt.mir = pkt.data[1:0];
					s_nxt.mir_move = 1'b1;
				end
				s_nxt.ack_acc = pp_ok || mir_ok;
				s_nxt.rej = !(pp_ok || mir_ok);
				s_nxt.last_ok = pp_ok || mir_ok;
				s_nxt.last_rej = !(pp_ok || mir_ok);
				if (pp_ok || mir_ok) begin
					s_nxt.nacc = s_r.nacc + 16'h0001;
				end else begin
					s_nxt.nrej = s_r.nrej + 16'h0001;
				end
			end
			ST_SEND: begin
				// data changes on falling edges, sampled on rising edges
				if (s_r.div == `SER_HALF_CYC - 8'h01) begin
					s_nxt.div = '0;
					if (!s_r.ser.clk) begin
						s_nxt.ser.clk = 1'b1;
					end else begin
						s_nxt.ser.clk = 1'b0;
						if (s_r.nbit == `WORD_LAST) begin
							s_nxt.ser.frame = 1'b0;
							s_nxt.ser.data = 1'b0;
							// execution acknowledged once a command word is out, not after a calibration word
							s_nxt.ack_exe = !s_r.cal_run;
							s_nxt.state = s_r.cal_run ? ST_CALGO : ST_COLLECT;
						end else begin
							s_nxt.nbit = s_r.nbit + 5'h01;
							s_nxt.sh = {s_r.sh[14:0], 1'b0};
							s_nxt.ser.data = s_r.sh[14];
						end
					end
				end else begin
					s_nxt.div = s_r.div + 8'h01;
				end
			end
			ST_CALGO: begin
				// calibration begins only after the word
				s_nxt.cal_go = 1'b1;
				s_nxt.cal_run = 1'b0;
				s_nxt.state = ST_COLLECT;
			end
		endcase

		// register writes; a new calibration request wins over its clear
		if (acc && pwrite) begin
			if (paddr == `A_CTRL) begin
				if (pwdata[`C_CLR]) begin
					s_nxt.idx = '0;
					s_nxt.crc = `CRC_INIT;
				end
				if (pwdata[`C_CAL]) begin
					s_nxt.cal_pend = 1'b1;
				end
			end else if (paddr == `A_PKT) begin
				s_nxt.pbuf = {s_r.pbuf[103:0], pwdata[7:0]};
				// checksum runs over all bytes ahead of the check word
				if (s_r.idx < `PEC_FIRST) begin
					s_nxt.crc = crc_upd(s_r.crc, pwdata[7:0]);
				end
				if (s_r.idx == `PKT_LAST) begin
					s_nxt.idx = '0;
					s_nxt.state = ST_CHECK;
				end else begin
					s_nxt.idx = s_r.idx + 4'h1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state register

	// reset loads position 410 and mirror at space
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
			s_r.ppos <= `PP_DEFAULT;
			s_r.mir <= `MIR_SPACE;
			s_r.crc <= `CRC_INIT;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	// outputs straight from the state register
	assign pready = s_r.pready;
	assign prdata = s_r.prdata;
	assign pslverr = s_r.pslverr;
	assign ser_out = s_r.ser;
	assign mirror_target = s_r.mir;
	assign mirror_move = s_r.mir_move;
	assign ack_accept = s_r.ack_acc;
	assign ack_exec = s_r.ack_exe;
	assign cal_start = s_r.cal_go;
	assign cmd_reject = s_r.rej;

	////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	AST_RST_PPOS: assert property ($rose(presetn) |-> s_r.ppos == `PP_DEFAULT)
		else $error("stored position not 410 after reset");

	AST_PP_NOW: assert property (ce && s_r.state == ST_CHECK && pp_ok
		|=> s_r.state == ST_SEND && s_r.ser.frame && ack_accept)
		else $error("position command not sent at once");

	AST_PP_WORD: assert property (ce && s_r.state == ST_CHECK && pp_ok
		|=> s_r.sh == $past(pkt.data) && s_r.ppos == $past(pkt.data))
		else $error("serial word does not carry command data");

	AST_TWO_CAUSES: assert property ($rose(s_r.ser.frame)
		|-> $past(s_r.state) == ST_CHECK || $past(cal_take))
		else $error("position sent without command or calibration");

	AST_CAL_AFTER: assert property (cal_start
		|-> $past(s_r.state) == ST_CALGO && !s_r.ser.frame && $past(s_r.ser.frame, 2))
		else $error("calibration started before position word");

	AST_CAL_STORED: assert property (ce && cal_take
		|=> s_r.ser.frame && s_r.sh == s_r.ppos && s_r.cal_run)
		else $error("calibration did not send stored position");

	AST_BAD_HDR: assert property (ce && s_r.state == ST_CHECK && !hdr_ok
		|=> cmd_reject && !ack_accept && !mirror_move && !s_r.ser.frame)
		else $error("bad header not rejected");

	AST_MIR_RANGE: assert property (ce && s_r.state == ST_CHECK && !mir_ok && !pp_ok
		|=> mirror_target == $past(s_r.mir))
		else $error("mirror moved on rejected command");

	AST_MIR_MOVE: assert property (mirror_move
		|-> mirror_target != 2'h0 && ack_accept && !ack_exec)
		else $error("mirror move with bad target or no ack");

	AST_EXEC_ACK: assert property (ack_exec
		|-> $past(s_r.ser.frame) && !s_r.ser.frame && !s_r.cal_run)
		else $error("execution ack not at end of word");

	COV_PP: cover property (ce && s_r.state == ST_CHECK && pp_ok);
	COV_MIR: cover property (mirror_move && mirror_target == `MIR_COLD);
	COV_CAL: cover property (cal_start);
	COV_REJ: cover property (cmd_reject);

endmodule
